// File: logic/nvmc_byte_access.sv
`include "nvmc_defs.svh"
`default_nettype none
module nvmc_byte_access
   import nvmc_pkg::*;
#(
   parameter int READ_CYCLES     = `NVMC_READ_CYCLES,
   parameter int WRITE_SUB_TICKS = `NVMC_WRITE_SUB_TICKS
) (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire nvmc_sfr_req_t sfr_req_i,
   output logic [7:0]         sfr_rdata_o,
   input  wire logic          global_int_enable_i,
   input  wire logic          stack_full_i,
   input  wire logic          int_ack_i,
   output logic               nvm_int_req_o,
   output logic               nvm_busy_o
);

   localparam int SUB_DIV = `NVMC_SUB_DIV;

   // Non-volatile array, no reset
   logic [7:0]             store [0:`NVMC_DEPTH-1];

   nvmc_ctrl_t             ctrl;
   nvmc_ctrl_t             next_ctrl;
   nvmc_state_t            state;
   nvmc_state_t            next_state;
   logic [`NVMC_ADDR_W-1:0] nvm_address;
   logic [`NVMC_ADDR_W-1:0] next_nvm_address;
   logic [7:0]             nvm_data;
   logic [7:0]             next_nvm_data;
   logic [7:0]             first_memory_pointer;
   logic [7:0]             next_first_memory_pointer;
   logic [2:0]             bank_select_register;
   logic [2:0]             next_bank_select_register;
   logic                   nvm_interrupt_enable;
   logic                   next_nvm_interrupt_enable;
   logic                   nvm_interrupt_request_flag;
   logic                   next_nvm_interrupt_request_flag;
   logic [7:0]             rd_cnt;
   logic [7:0]             next_rd_cnt;
   logic [9:0]             sub_cnt;
   logic [9:0]             next_sub_cnt;
   logic [15:0]            wr_cnt;
   logic [15:0]            next_wr_cnt;
   logic                   timer_done;
   logic                   next_timer_done;
   logic                   done_meta;
   logic                   done_sync;
   logic [7:0]             next_rdata;
   logic                   sub_tick;
   logic                   ind_hit;
   logic                   wr_ctrl;
   logic                   start_write;
   logic                   start_read;
   logic                   read_end;
   logic                   data_load;
   logic                   mem_we;
   logic [7:0]             rd_byte;

   // Indirect port reaches control only at pointer 40H in bank 1
   assign ind_hit = (bank_select_register == `NVMC_CTRL_BANK) &&
                    (first_memory_pointer == `NVMC_CTRL_OFS);
   assign wr_ctrl = sfr_req_i.wr && (sfr_req_i.addr == `NVMC_IND1_OFS) && ind_hit;
   assign rd_byte = store[nvm_address];

   // Substitute clock enable for the write timer
   always_comb begin
      sub_tick     = (sub_cnt == 10'(SUB_DIV - 1));
      next_sub_cnt = sub_tick ? 10'h000 : 10'(sub_cnt + 10'h001);
   end

   // Register file, triggers and access sequencer
   always_comb begin
      next_ctrl                       = ctrl;
      next_state                      = state;
      next_nvm_address                = nvm_address;
      next_nvm_data                   = nvm_data;
      next_first_memory_pointer       = first_memory_pointer;
      next_bank_select_register       = bank_select_register;
      next_nvm_interrupt_enable       = nvm_interrupt_enable;
      next_nvm_interrupt_request_flag = nvm_interrupt_request_flag;
      next_rd_cnt                     = rd_cnt;
      next_wr_cnt                     = wr_cnt;
      next_timer_done                 = timer_done;
      start_write                     = 1'b0;
      start_read                      = 1'b0;
      read_end                        = 1'b0;
      data_load                       = 1'b0;
      mem_we                          = 1'b0;

      // Clears first so that a same-cycle set wins
      if (int_ack_i) begin
         next_nvm_interrupt_request_flag = 1'b0;
      end

      if (sfr_req_i.wr) begin
         case (sfr_req_i.addr)
            `NVMC_ADDR_OFS: begin
               next_nvm_address = sfr_req_i.wdata[`NVMC_ADDR_W-1:0];
            end
            `NVMC_DATA_OFS: begin
               next_nvm_data = sfr_req_i.wdata;
            end
            `NVMC_PTR1_OFS: begin
               next_first_memory_pointer = sfr_req_i.wdata;
            end
            `NVMC_BANK_OFS: begin
               next_bank_select_register = sfr_req_i.wdata[2:0];
            end
            `NVMC_INTC_OFS: begin
               next_nvm_interrupt_enable = sfr_req_i.wdata[`NVMC_IEN_BIT];
               if (!sfr_req_i.wdata[`NVMC_IFLAG_BIT]) begin
                  next_nvm_interrupt_request_flag = 1'b0;
               end
            end
            `NVMC_IND1_OFS: begin
               if (ind_hit) begin
                  next_ctrl.write_enable_gate = sfr_req_i.wdata[`NVMC_WEN_BIT];
                  next_ctrl.read_enable_gate  = sfr_req_i.wdata[`NVMC_REN_BIT];
               end
            end
            default: begin
            end
         endcase
      end

      // Triggers act only when their gate was set beforehand
      if (wr_ctrl && (state == ST_IDLE)) begin
         if (sfr_req_i.wdata[`NVMC_WTRIG_BIT] && ctrl.write_enable_gate) begin
            start_write = 1'b1;
         end else if (sfr_req_i.wdata[`NVMC_RTRIG_BIT] && ctrl.read_enable_gate) begin
            start_read = 1'b1;
         end
      end

      case (state)
         ST_IDLE: begin
            if (start_write) begin
               next_ctrl.write_trigger = 1'b1;
               next_wr_cnt             = 16'h0000;
               next_timer_done         = 1'b0;
               next_state              = ST_WRITE;
            end else if (start_read) begin
               next_ctrl.read_trigger = 1'b1;
               next_rd_cnt            = 8'h00;
               next_state             = ST_READ;
            end
         end
         ST_READ: begin
            if (!ctrl.read_enable_gate) begin
               next_ctrl.read_trigger = 1'b0;
               next_state             = ST_IDLE;
            end else if (rd_cnt == 8'(READ_CYCLES - 1)) begin
               read_end               = 1'b1;
               data_load              = 1'b1;
               next_nvm_data          = rd_byte;
               next_ctrl.read_trigger = 1'b0;
               next_state             = ST_IDLE;
            end else begin
               next_rd_cnt = 8'(rd_cnt + 8'h01);
            end
         end
         ST_WRITE: begin
            if (sub_tick && !timer_done) begin
               if (wr_cnt == 16'(WRITE_SUB_TICKS - 1)) begin
                  next_timer_done = 1'b1;
               end else begin
                  next_wr_cnt = 16'(wr_cnt + 16'h0001);
               end
            end
            if (timer_done && done_sync) begin
               mem_we                          = ctrl.write_enable_gate;
               next_ctrl.write_trigger         = 1'b0;
               next_timer_done                 = 1'b0;
               next_nvm_interrupt_request_flag = 1'b1;
               next_state                      = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Readback, upper unimplemented bits read as zero
   always_comb begin
      case (sfr_req_i.addr)
         `NVMC_ADDR_OFS: next_rdata = {1'b0, nvm_address};
         `NVMC_DATA_OFS: next_rdata = nvm_data;
         `NVMC_PTR1_OFS: next_rdata = first_memory_pointer;
         `NVMC_BANK_OFS: next_rdata = {5'h00, bank_select_register};
         `NVMC_INTC_OFS: next_rdata = {6'h00, nvm_interrupt_request_flag,
                                       nvm_interrupt_enable};
         `NVMC_IND1_OFS: next_rdata = ind_hit ? {4'h0, ctrl[3:0]} : 8'h00;
         default:        next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl                       <= '0;
         state                      <= ST_IDLE;
         nvm_address                <= `NVMC_ADDR_W'(`NVMC_BYTE_RST);
         nvm_data                   <= `NVMC_BYTE_RST;
         first_memory_pointer       <= `NVMC_BYTE_RST;
         bank_select_register       <= `NVMC_BANK_RST;
         nvm_interrupt_enable       <= 1'b0;
         nvm_interrupt_request_flag <= 1'b0;
         rd_cnt                     <= 8'h00;
         sub_cnt                    <= 10'h000;
         wr_cnt                     <= 16'h0000;
         timer_done                 <= 1'b0;
         done_meta                  <= 1'b0;
         done_sync                  <= 1'b0;
         sfr_rdata_o                <= `NVMC_BYTE_RST;
      end else begin
         ctrl                       <= next_ctrl;
         state                      <= next_state;
         nvm_address                <= next_nvm_address;
         nvm_data                   <= next_nvm_data;
         first_memory_pointer       <= next_first_memory_pointer;
         bank_select_register       <= next_bank_select_register;
         nvm_interrupt_enable       <= next_nvm_interrupt_enable;
         nvm_interrupt_request_flag <= next_nvm_interrupt_request_flag;
         rd_cnt                     <= next_rd_cnt;
         sub_cnt                    <= next_sub_cnt;
         wr_cnt                     <= next_wr_cnt;
         timer_done                 <= next_timer_done;
         done_meta                  <= timer_done;
         done_sync                  <= done_meta;
         sfr_rdata_o                <= next_rdata;
      end
   end

   // Byte-wide store update
   always_ff @(posedge clk_i) begin
      if (mem_we) begin
         store[nvm_address] <= nvm_data;
      end
   end

   assign nvm_int_req_o = nvm_interrupt_request_flag && nvm_interrupt_enable &&
                          global_int_enable_i && !stack_full_i;
   assign nvm_busy_o    = (state != ST_IDLE);

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence seq_read_go;
      start_read;
   endsequence

   sequence seq_read_hold;
      ctrl.read_trigger [*2];
   endsequence

   sequence seq_write_end;
      $fell(ctrl.write_trigger);
   endsequence

   chk_addr_msb_zero: assert property (
      (!sfr_req_i.wr && sfr_req_i.addr == `NVMC_ADDR_OFS) |=> sfr_rdata_o[7] == 1'b0)
      else $error("address readback bit 7 not zero");

   chk_ctrl_upper_zero: assert property (
      (sfr_req_i.addr == `NVMC_IND1_OFS) |=> sfr_rdata_o[7:4] == 4'h0)
      else $error("control readback upper bits not zero");

   chk_write_gated: assert property (
      (wr_ctrl && sfr_req_i.wdata[`NVMC_WTRIG_BIT] && !ctrl.write_enable_gate &&
       !ctrl.write_trigger) |=> !ctrl.write_trigger)
      else $error("write trigger set without write gate");

   chk_read_gated: assert property (
      (wr_ctrl && sfr_req_i.wdata[`NVMC_RTRIG_BIT] && !ctrl.read_enable_gate &&
       !ctrl.read_trigger) |=> !ctrl.read_trigger)
      else $error("read trigger set without read gate");

   chk_read_hold: assert property (
      seq_read_go |=> seq_read_hold)
      else $error("read trigger dropped too early");

   chk_read_bound: assert property (
      seq_read_go |-> ##[2:64] !ctrl.read_trigger)
      else $error("read cycle did not finish");

   chk_read_loads: assert property (
      read_end |=> nvm_data == $past(rd_byte) && !ctrl.read_trigger)
      else $error("read data not loaded at read end");

   chk_data_hold: assert property (
      (!data_load && !(sfr_req_i.wr && sfr_req_i.addr == `NVMC_DATA_OFS))
      |=> $stable(nvm_data))
      else $error("data register changed without an operation");

   chk_write_sync: assert property (
      seq_write_end |-> $past(done_sync) && $past(timer_done))
      else $error("write trigger cleared before synchronised done");

   chk_write_flag: assert property (
      seq_write_end |-> nvm_interrupt_request_flag)
      else $error("write end did not raise request flag");

   chk_write_gate: assert property (
      mem_we |-> ctrl.write_enable_gate && state == ST_WRITE)
      else $error("store written without write gate");

   chk_flag_ack: assert property (
      (int_ack_i && !(timer_done && done_sync && state == ST_WRITE))
      |=> !nvm_interrupt_request_flag)
      else $error("serviced request flag not cleared");

endmodule : nvmc_byte_access
`default_nettype wire

// File: logic/nvmc_defs.svh
`ifndef NVMC_DEFS_SVH
`define NVMC_DEFS_SVH

// Store geometry
`define NVMC_DEPTH           128
`define NVMC_ADDR_W          7
`define NVMC_BYTE_RST        8'h00

// Special function register addresses, reachable in every bank
`define NVMC_IND1_OFS        8'h00
`define NVMC_PTR1_OFS        8'h03
`define NVMC_BANK_OFS        8'h04
`define NVMC_INTC_OFS        8'h0E
`define NVMC_ADDR_OFS        8'h2A
`define NVMC_DATA_OFS        8'h2B

// Control register location behind the indirect port
`define NVMC_CTRL_OFS        8'h40
`define NVMC_CTRL_BANK       3'h1
`define NVMC_BANK_RST        3'h0

// Control register bit positions
`define NVMC_WEN_BIT         3
`define NVMC_WTRIG_BIT       2
`define NVMC_REN_BIT         1
`define NVMC_RTRIG_BIT       0

// Interrupt control register bit positions
`define NVMC_IEN_BIT         0
`define NVMC_IFLAG_BIT       1

// Clock rates and cycle figures
`define NVMC_SYS_CLK_HZ      20000000
`define NVMC_SUB_CLK_HZ      32000
`define NVMC_SUB_DIV         (`NVMC_SYS_CLK_HZ / `NVMC_SUB_CLK_HZ)
`define NVMC_READ_CYCLES     4
`define NVMC_WRITE_SUB_TICKS 64

`endif

// File: logic/nvmc_pkg.sv
`default_nettype none
package nvmc_pkg;

   typedef struct packed {
      logic [3:0] unused;
      logic       write_enable_gate;
      logic       write_trigger;
      logic       read_enable_gate;
      logic       read_trigger;
   } nvmc_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } nvmc_sfr_req_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } nvmc_state_t;

endpackage : nvmc_pkg
`default_nettype wire

// File: test/nvmc_byte_access_tb.sv
`include "nvmc_defs.svh"
`default_nettype none
module nvmc_byte_access_tb import nvmc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int RD_N     = 4;
   localparam int WR_TICKS = 2;
   localparam int LIMIT    = 20000;

   logic          clk;
   logic          rst_n;
   logic          gie;
   logic          stk;
   logic          ack;
   nvmc_sfr_req_t req;
   logic [7:0]    rdata;
   logic          irq;
   logic          busy;
   int            err_total;
   int            n_tests;
   int            cyc;

   nvmc_byte_access #(.READ_CYCLES(RD_N), .WRITE_SUB_TICKS(WR_TICKS)) u_dut (
      .clk_i               (clk),
      .rst_n_i             (rst_n),
      .sfr_req_i           (req),
      .sfr_rdata_o         (rdata),
      .global_int_enable_i (gie),
      .stack_full_i        (stk),
      .int_ack_i           (ack),
      .nvm_int_req_o       (irq),
      .nvm_busy_o          (busy)
   );

   always #25 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err_total++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      req.wr    = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      req.addr = a;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk({7'h00, busy}, 8'h00);
   endtask : wait_idle

   task automatic nvm_write(input logic [7:0] a, input logic [7:0] d, input logic drop);
      wr(`NVMC_ADDR_OFS, a);
      wr(`NVMC_DATA_OFS, d);
      wr(`NVMC_IND1_OFS, 8'h08);
      wr(`NVMC_IND1_OFS, 8'h0C);
      chk({7'h00, busy}, 8'h01);
      if (drop) begin
         wr(`NVMC_IND1_OFS, 8'h00);
      end
      wait_idle();
      rd(`NVMC_IND1_OFS, drop ? 8'h00 : 8'h08);
   endtask : nvm_write

   task automatic nvm_read(input logic [7:0] a, input logic [7:0] exp);
      int n;
      wr(`NVMC_DATA_OFS, 8'h00);
      wr(`NVMC_ADDR_OFS, a);
      wr(`NVMC_IND1_OFS, 8'h02);
      wr(`NVMC_IND1_OFS, 8'h03);
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk(8'(n), 8'(RD_N));
      rd(`NVMC_IND1_OFS, 8'h02);
      rd(`NVMC_DATA_OFS, exp);
   endtask : nvm_read

   task automatic t_reset();
      rd(`NVMC_ADDR_OFS, 8'h00);
      rd(`NVMC_DATA_OFS, 8'h00);
      rd(`NVMC_BANK_OFS, 8'h00);
      rd(`NVMC_PTR1_OFS, 8'h00);
      rd(`NVMC_INTC_OFS, 8'h00);
      chk({6'h00, busy, irq}, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs();
      wr(`NVMC_ADDR_OFS, 8'hFF);
      rd(`NVMC_ADDR_OFS, 8'h7F);
      wr(`NVMC_DATA_OFS, 8'hA5);
      rd(`NVMC_DATA_OFS, 8'hA5);
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h00);
      $display("test regs done");
   endtask : t_regs

   task automatic t_ctrl();
      wr(`NVMC_PTR1_OFS, 8'h40);
      wr(`NVMC_IND1_OFS, 8'h0A);
      rd(`NVMC_IND1_OFS, 8'h00);
      wr(`NVMC_BANK_OFS, 8'h01);
      rd(`NVMC_BANK_OFS, 8'h01);
      rd(`NVMC_IND1_OFS, 8'h00);
      wr(`NVMC_IND1_OFS, 8'hFF);
      rd(`NVMC_IND1_OFS, 8'h0A);
      chk({7'h00, busy}, 8'h00);
      wr(`NVMC_IND1_OFS, 8'h00);
      wr(`NVMC_IND1_OFS, 8'h05);
      rd(`NVMC_IND1_OFS, 8'h00);
      chk({7'h00, busy}, 8'h00);
      $display("test ctrl done");
   endtask : t_ctrl

   task automatic t_write_irq();
      nvm_write(8'h05, 8'h3C, 1'b0);
      rd(`NVMC_INTC_OFS, 8'h02);
      gie = 1'b1;
      #1 chk({7'h00, irq}, 8'h00);
      wr(`NVMC_INTC_OFS, 8'h03);
      rd(`NVMC_INTC_OFS, 8'h03);
      chk({7'h00, irq}, 8'h01);
      @(negedge clk);
      stk = 1'b1;
      #1 chk({7'h00, irq}, 8'h00);
      @(negedge clk);
      stk = 1'b0;
      gie = 1'b0;
      #1 chk({7'h00, irq}, 8'h00);
      @(negedge clk);
      gie = 1'b1;
      ack = 1'b1;
      @(negedge clk);
      ack = 1'b0;
      chk({7'h00, irq}, 8'h00);
      rd(`NVMC_INTC_OFS, 8'h01);
      $display("test write irq done");
   endtask : t_write_irq

   task automatic t_read();
      gie = 1'b0;
      nvm_write(8'h06, 8'hC3, 1'b0);
      nvm_read(8'h05, 8'h3C);
      wr(`NVMC_ADDR_OFS, 8'h06);
      rd(`NVMC_DATA_OFS, 8'h3C);
      nvm_read(8'h06, 8'hC3);
      $display("test read done");
   endtask : t_read

   task automatic t_block();
      gie = 1'b0;
      wr(`NVMC_INTC_OFS, 8'h00);
      nvm_write(8'h05, 8'h99, 1'b1);
      rd(`NVMC_INTC_OFS, 8'h02);
      wr(`NVMC_INTC_OFS, 8'h00);
      rd(`NVMC_INTC_OFS, 8'h00);
      nvm_read(8'h05, 8'h3C);
      $display("test block done");
   endtask : t_block

   task automatic t_abort();
      wr(`NVMC_DATA_OFS, 8'h55);
      wr(`NVMC_IND1_OFS, 8'h03);
      wr(`NVMC_IND1_OFS, 8'h00);
      wait_idle();
      rd(`NVMC_DATA_OFS, 8'h55);
      rd(`NVMC_IND1_OFS, 8'h00);
      $display("test abort done");
   endtask : t_abort

   task automatic t_rerun();
      wr(`NVMC_INTC_OFS, 8'h01);
      wr(`NVMC_ADDR_OFS, 8'h7F);
      wr(`NVMC_DATA_OFS, 8'h11);
      wr(`NVMC_IND1_OFS, 8'h0A);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      wr(`NVMC_PTR1_OFS, 8'h40);
      wr(`NVMC_BANK_OFS, 8'h01);
      rd(`NVMC_IND1_OFS, 8'h00);
      nvm_read(8'h05, 8'h3C);
      $display("test second reset done");
   endtask : t_rerun

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   initial begin
      clk       = 1'b0;
      rst_n     = 1'b0;
      req       = '0;
      gie       = 1'b0;
      stk       = 1'b0;
      ack       = 1'b0;
      err_total = 0;
      n_tests   = 0;
      cyc       = 0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_regs();
      t_ctrl();
      t_write_irq();
      t_read();
      t_block();
      t_abort();
      t_rerun();
      results();
   end

endmodule : nvmc_byte_access_tb
`default_nettype wire
